// ### rtl/cei_consts.svh
// Register offsets, field positions, reset values and masks for the converter event bank
`ifndef CEI_CONSTS_SVH
`define CEI_CONSTS_SVH

// Register offsets on the serial control port
`define CEI_ADDR_EN_MAIN     12'h020
`define CEI_ADDR_EN_CONV0    12'h021
`define CEI_ADDR_EN_CONV1    12'h022
`define CEI_ADDR_EN_CLOCKING 12'h023
`define CEI_ADDR_ST_MAIN     12'h024
`define CEI_ADDR_ST_CONV0    12'h025
`define CEI_ADDR_ST_CONV1    12'h026
`define CEI_ADDR_ST_CLOCKING 12'h027

// Reset value shared by every enable and status register
`define CEI_RESET_BYTE 8'h00
`define CEI_RESET_EVT  13'h0000

// Implemented bits of each register; all other bits are reserved
`define CEI_MASK_MAIN     8'h1f
`define CEI_MASK_CONV     8'h09
`define CEI_MASK_CLOCKING 8'h33

// Bit positions inside the main registers
`define CEI_BIT_REF_JITTER 4
`define CEI_BIT_DATA_LOW   3
`define CEI_BIT_LANE_FIFO  2
`define CEI_BIT_PAT_IMAG   1
`define CEI_BIT_PAT_REAL   0

// Bit positions inside the per-converter registers
`define CEI_BIT_CAL_DONE   3
`define CEI_BIT_AMP_ERR    0

// Bit positions inside the clocking registers
`define CEI_BIT_DLL_LOST   5
`define CEI_BIT_DLL_LOCK   4
`define CEI_BIT_PLL_LOST   1
`define CEI_BIT_PLL_LOCK   0

// Positions in the internal event vector
`define CEI_EV_PAT_REAL    0
`define CEI_EV_PAT_IMAG    1
`define CEI_EV_LANE_FIFO   2
`define CEI_EV_DATA_LOW    3
`define CEI_EV_REF_JITTER  4
`define CEI_EV_C0_AMP      5
`define CEI_EV_C0_CAL      6
`define CEI_EV_C1_AMP      7
`define CEI_EV_C1_CAL      8
`define CEI_EV_PLL_LOCK    9
`define CEI_EV_PLL_LOST    10
`define CEI_EV_DLL_LOCK    11
`define CEI_EV_DLL_LOST    12
`define CEI_NUM_EVENTS     13

`endif

// ### rtl/cei_pkg.sv
// Types shared by the converter event bank
`include "cei_consts.svh"
package cei_pkg;
   typedef logic [7:0]                   cei_byte_type;
   typedef logic [11:0]                  cei_addr_type;
   typedef logic [`CEI_NUM_EVENTS-1:0]   cei_evt_type;
endpackage : cei_pkg

// ### rtl/cei_event_bank.sv
// Converter event enable, status and interrupt pin logic
`timescale 1ns/1ps
`default_nettype none
`include "cei_consts.svh"

module cei_event_bank (
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic                  reg_wr_en,
   input  wire logic                  reg_rd_en,
   input  wire cei_pkg::cei_addr_type reg_addr,
   input  wire cei_pkg::cei_byte_type reg_wr_data,
   output var  cei_pkg::cei_byte_type reg_rd_data,
   output var  logic                  reg_rd_valid,
   input  wire logic                  ref_jitter_cond,
   input  wire logic                  link_receiver_ready,
   input  wire logic                  lane_fifo_fault,
   input  wire logic                  pattern_err_imag,
   input  wire logic                  pattern_err_real,
   input  wire logic                  conv0_cal_complete,
   input  wire logic                  conv0_amp_protect,
   input  wire logic                  conv1_cal_complete,
   input  wire logic                  conv1_amp_protect,
   input  wire logic                  dll_locked,
   input  wire logic                  dll_lock_lost,
   input  wire logic                  pll_locked,
   input  wire logic                  pll_lock_lost,
   input  wire cei_pkg::cei_evt_type  event_pin_select,
   output var  logic                  interrupt_out_first_n,
   output var  logic                  interrupt_out_second_n
);
   import cei_pkg::*;

   cei_byte_type en_main_r;
   cei_byte_type en_conv0_r;
   cei_byte_type en_conv1_r;
   cei_byte_type en_clocking_r;
   cei_evt_type  flag_r;
   cei_evt_type  flag_nxt;
   cei_evt_type  en_vec;
   cei_evt_type  cond_vec;
   cei_evt_type  clr_vec;
   cei_byte_type st_main;
   cei_byte_type st_conv0;
   cei_byte_type st_conv1;
   cei_byte_type st_clocking;
   cei_byte_type rd_nxt;
   logic         first_nxt_n;
   logic         second_nxt_n;

   // All checks below run on the system clock and sleep during reset
   default clocking cb_sys @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Enable registers; reserved bits are masked so they never store
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         en_main_r     <= `CEI_RESET_BYTE;
         en_conv0_r    <= `CEI_RESET_BYTE;
         en_conv1_r    <= `CEI_RESET_BYTE;
         en_clocking_r <= `CEI_RESET_BYTE;
      end else if (reg_wr_en) begin
         if (reg_addr == `CEI_ADDR_EN_MAIN) begin
            en_main_r <= reg_wr_data & `CEI_MASK_MAIN;
         end
         if (reg_addr == `CEI_ADDR_EN_CONV0) begin
            en_conv0_r <= reg_wr_data & `CEI_MASK_CONV;
         end
         if (reg_addr == `CEI_ADDR_EN_CONV1) begin
            en_conv1_r <= reg_wr_data & `CEI_MASK_CONV;
         end
         if (reg_addr == `CEI_ADDR_EN_CLOCKING) begin
            en_clocking_r <= reg_wr_data & `CEI_MASK_CLOCKING;
         end
      end
   end

   // Per-event enable vector gathered from the four enable registers
   always_comb begin
      en_vec = `CEI_RESET_EVT;
      en_vec[`CEI_EV_REF_JITTER] = en_main_r[`CEI_BIT_REF_JITTER];
      en_vec[`CEI_EV_DATA_LOW]   = en_main_r[`CEI_BIT_DATA_LOW];
      en_vec[`CEI_EV_LANE_FIFO]  = en_main_r[`CEI_BIT_LANE_FIFO];
      en_vec[`CEI_EV_PAT_IMAG]   = en_main_r[`CEI_BIT_PAT_IMAG];
      en_vec[`CEI_EV_PAT_REAL]   = en_main_r[`CEI_BIT_PAT_REAL];
      en_vec[`CEI_EV_C0_CAL]     = en_conv0_r[`CEI_BIT_CAL_DONE];
      en_vec[`CEI_EV_C0_AMP]     = en_conv0_r[`CEI_BIT_AMP_ERR];
      en_vec[`CEI_EV_C1_CAL]     = en_conv1_r[`CEI_BIT_CAL_DONE];
      en_vec[`CEI_EV_C1_AMP]     = en_conv1_r[`CEI_BIT_AMP_ERR];
      en_vec[`CEI_EV_DLL_LOST]   = en_clocking_r[`CEI_BIT_DLL_LOST];
      en_vec[`CEI_EV_DLL_LOCK]   = en_clocking_r[`CEI_BIT_DLL_LOCK];
      en_vec[`CEI_EV_PLL_LOST]   = en_clocking_r[`CEI_BIT_PLL_LOST];
      en_vec[`CEI_EV_PLL_LOCK]   = en_clocking_r[`CEI_BIT_PLL_LOCK];
   end

   // Live conditions; the receiver event is the ready line being low
   always_comb begin
      cond_vec = `CEI_RESET_EVT;
      cond_vec[`CEI_EV_REF_JITTER] = ref_jitter_cond;
      cond_vec[`CEI_EV_DATA_LOW]   = ~link_receiver_ready;
      cond_vec[`CEI_EV_LANE_FIFO]  = lane_fifo_fault;
      cond_vec[`CEI_EV_PAT_IMAG]   = pattern_err_imag;
      cond_vec[`CEI_EV_PAT_REAL]   = pattern_err_real;
      cond_vec[`CEI_EV_C0_CAL]     = conv0_cal_complete;
      cond_vec[`CEI_EV_C0_AMP]     = conv0_amp_protect;
      cond_vec[`CEI_EV_C1_CAL]     = conv1_cal_complete;
      cond_vec[`CEI_EV_C1_AMP]     = conv1_amp_protect;
      cond_vec[`CEI_EV_DLL_LOST]   = dll_lock_lost;
      cond_vec[`CEI_EV_DLL_LOCK]   = dll_locked;
      cond_vec[`CEI_EV_PLL_LOST]   = pll_lock_lost;
      cond_vec[`CEI_EV_PLL_LOCK]   = pll_locked;
   end

   // Write-one-to-clear requests decoded per status register
   always_comb begin
      clr_vec = `CEI_RESET_EVT;
      if (reg_wr_en) begin
         if (reg_addr == `CEI_ADDR_ST_MAIN) begin
            clr_vec[`CEI_EV_REF_JITTER] = reg_wr_data[`CEI_BIT_REF_JITTER];
            clr_vec[`CEI_EV_DATA_LOW]   = reg_wr_data[`CEI_BIT_DATA_LOW];
            clr_vec[`CEI_EV_LANE_FIFO]  = reg_wr_data[`CEI_BIT_LANE_FIFO];
            clr_vec[`CEI_EV_PAT_IMAG]   = reg_wr_data[`CEI_BIT_PAT_IMAG];
            clr_vec[`CEI_EV_PAT_REAL]   = reg_wr_data[`CEI_BIT_PAT_REAL];
         end
         if (reg_addr == `CEI_ADDR_ST_CONV0) begin
            clr_vec[`CEI_EV_C0_CAL] = reg_wr_data[`CEI_BIT_CAL_DONE];
            clr_vec[`CEI_EV_C0_AMP] = reg_wr_data[`CEI_BIT_AMP_ERR];
         end
         if (reg_addr == `CEI_ADDR_ST_CONV1) begin
            clr_vec[`CEI_EV_C1_CAL] = reg_wr_data[`CEI_BIT_CAL_DONE];
            clr_vec[`CEI_EV_C1_AMP] = reg_wr_data[`CEI_BIT_AMP_ERR];
         end
         if (reg_addr == `CEI_ADDR_ST_CLOCKING) begin
            clr_vec[`CEI_EV_DLL_LOST] = reg_wr_data[`CEI_BIT_DLL_LOST];
            clr_vec[`CEI_EV_DLL_LOCK] = reg_wr_data[`CEI_BIT_DLL_LOCK];
            clr_vec[`CEI_EV_PLL_LOST] = reg_wr_data[`CEI_BIT_PLL_LOST];
            clr_vec[`CEI_EV_PLL_LOCK] = reg_wr_data[`CEI_BIT_PLL_LOCK];
         end
      end
   end

   // Disabled bits mirror the condition; enabled bits hold until cleared.
   // A condition still present keeps the bit set, so set wins over clear.
   always_comb begin
      flag_nxt = cond_vec | (en_vec & flag_r & ~clr_vec);
   end

   // Status flags
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flag_r <= `CEI_RESET_EVT;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // Pin drive uses the next flag value so pin and status move together
   always_comb begin
      first_nxt_n  = ~|(flag_nxt & en_vec & ~event_pin_select);
      second_nxt_n = ~|(flag_nxt & en_vec & event_pin_select);
   end

   // Active-low interrupt pins, released during reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         interrupt_out_first_n  <= 1'b1;
         interrupt_out_second_n <= 1'b1;
      end else begin
         interrupt_out_first_n  <= first_nxt_n;
         interrupt_out_second_n <= second_nxt_n;
      end
   end

   // Status bytes; reserved positions stay zero
   always_comb begin
      st_main  = `CEI_RESET_BYTE;
      st_conv0 = `CEI_RESET_BYTE;
      st_conv1 = `CEI_RESET_BYTE;
      st_clocking = `CEI_RESET_BYTE;
      st_main[`CEI_BIT_REF_JITTER] = flag_r[`CEI_EV_REF_JITTER];
      st_main[`CEI_BIT_DATA_LOW]   = flag_r[`CEI_EV_DATA_LOW];
      st_main[`CEI_BIT_LANE_FIFO]  = flag_r[`CEI_EV_LANE_FIFO];
      st_main[`CEI_BIT_PAT_IMAG]   = flag_r[`CEI_EV_PAT_IMAG];
      st_main[`CEI_BIT_PAT_REAL]   = flag_r[`CEI_EV_PAT_REAL];
      st_conv0[`CEI_BIT_CAL_DONE]  = flag_r[`CEI_EV_C0_CAL];
      st_conv0[`CEI_BIT_AMP_ERR]   = flag_r[`CEI_EV_C0_AMP];
      st_conv1[`CEI_BIT_CAL_DONE]  = flag_r[`CEI_EV_C1_CAL];
      st_conv1[`CEI_BIT_AMP_ERR]   = flag_r[`CEI_EV_C1_AMP];
      st_clocking[`CEI_BIT_DLL_LOST] = flag_r[`CEI_EV_DLL_LOST];
      st_clocking[`CEI_BIT_DLL_LOCK] = flag_r[`CEI_EV_DLL_LOCK];
      st_clocking[`CEI_BIT_PLL_LOST] = flag_r[`CEI_EV_PLL_LOST];
      st_clocking[`CEI_BIT_PLL_LOCK] = flag_r[`CEI_EV_PLL_LOCK];
   end

   // Read mux; unmapped offsets answer zero
   always_comb begin
      unique case (reg_addr)
         `CEI_ADDR_EN_MAIN:     rd_nxt = en_main_r;
         `CEI_ADDR_EN_CONV0:    rd_nxt = en_conv0_r;
         `CEI_ADDR_EN_CONV1:    rd_nxt = en_conv1_r;
         `CEI_ADDR_EN_CLOCKING: rd_nxt = en_clocking_r;
         `CEI_ADDR_ST_MAIN:     rd_nxt = st_main;
         `CEI_ADDR_ST_CONV0:    rd_nxt = st_conv0;
         `CEI_ADDR_ST_CONV1:    rd_nxt = st_conv1;
         `CEI_ADDR_ST_CLOCKING: rd_nxt = st_clocking;
         default:               rd_nxt = `CEI_RESET_BYTE;
      endcase
   end

   // Read data is registered; it holds until the next read
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         reg_rd_data  <= `CEI_RESET_BYTE;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rd_data <= rd_nxt;
         end
      end
   end

   // Latched bit with a clear and no live condition drops next cycle
   sequence s_clear_req;
      reg_wr_en && (reg_addr == `CEI_ADDR_ST_MAIN) && reg_wr_data[`CEI_BIT_LANE_FIFO]
         && en_main_r[`CEI_BIT_LANE_FIFO] && !lane_fifo_fault;
   endsequence
   sequence s_cleared;
      !flag_r[`CEI_EV_LANE_FIFO]
         ##0 ((reg_rd_en ##1 !reg_rd_data[`CEI_BIT_LANE_FIFO]) or !reg_rd_en);
   endsequence

   a_clear_drops: assert property (s_clear_req |=> s_cleared)
      else $error("Write-one clear did not drop the lane FIFO flag");

   a_live_follow: assert property (1'b1 |=>
      ((flag_r & ~$past(en_vec)) == ($past(cond_vec) & ~$past(en_vec))))
      else $error("Disabled status bit does not follow its condition");

   a_latch_hold: assert property (1'b1 |=>
      (($past(en_vec & flag_r & ~clr_vec) & ~flag_r) == `CEI_RESET_EVT))
      else $error("Latched status bit lost without a clear");

   a_set_wins: assert property (1'b1 |=>
      (($past(cond_vec) & ~flag_r) == `CEI_RESET_EVT))
      else $error("Present condition failed to set its status bit");

   a_pin_first: assert property (1'b1 |=>
      (interrupt_out_first_n == !(|(flag_r & $past(en_vec) & ~$past(event_pin_select)))))
      else $error("First interrupt pin disagrees with routed latched flags");

   a_pin_second: assert property (1'b1 |=>
      (interrupt_out_second_n == !(|(flag_r & $past(en_vec) & $past(event_pin_select)))))
      else $error("Second interrupt pin disagrees with routed latched flags");

   a_jitter_gate: assert property ((!en_main_r[`CEI_BIT_REF_JITTER])
      && ref_jitter_cond && !(reg_wr_en && reg_addr == `CEI_ADDR_EN_MAIN)
      && (en_vec & ~(13'h0001 << `CEI_EV_REF_JITTER)) == `CEI_RESET_EVT
      |=> interrupt_out_first_n && interrupt_out_second_n)
      else $error("Disabled jitter event drove an interrupt pin");

   a_rd_reserved: assert property (reg_rd_en && (reg_addr == `CEI_ADDR_EN_CLOCKING)
      |=> reg_rd_valid && ((reg_rd_data & ~`CEI_MASK_CLOCKING) == `CEI_RESET_BYTE)
          && (reg_rd_data == $past(en_clocking_r)))
      else $error("Clocking enable read wrong or reserved bits set");

   a_status_main: assert property (reg_rd_en && (reg_addr == `CEI_ADDR_ST_MAIN)
      |=> reg_rd_data == {3'h0, $past(flag_r[`CEI_EV_REF_JITTER:`CEI_EV_PAT_REAL])})
      else $error("Main status read does not match event flags");

   // Register port: stored main enable, read back of every group, unmapped offsets
   a_en_main_wr: assert property (reg_wr_en && (reg_addr == `CEI_ADDR_EN_MAIN)
      |=> en_main_r == ($past(reg_wr_data) & `CEI_MASK_MAIN))
      else $error("Main enable write stored wrong value");

   a_rd_main_en: assert property (reg_rd_en && (reg_addr == `CEI_ADDR_EN_MAIN)
      |=> ((reg_rd_data & ~`CEI_MASK_MAIN) == `CEI_RESET_BYTE)
          && (reg_rd_data == $past(en_main_r)))
      else $error("Main enable read wrong or reserved bits set");

   a_rd_conv0: assert property (reg_rd_en && (reg_addr == `CEI_ADDR_EN_CONV0)
      |=> ((reg_rd_data & ~`CEI_MASK_CONV) == `CEI_RESET_BYTE)
          && (reg_rd_data == $past(en_conv0_r)))
      else $error("Converter 0 enable read wrong or reserved bits set");

   a_rd_conv1: assert property (reg_rd_en && (reg_addr == `CEI_ADDR_EN_CONV1)
      |=> ((reg_rd_data & ~`CEI_MASK_CONV) == `CEI_RESET_BYTE)
          && (reg_rd_data == $past(en_conv1_r)))
      else $error("Converter 1 enable read wrong or reserved bits set");

   a_status_conv0: assert property (reg_rd_en && (reg_addr == `CEI_ADDR_ST_CONV0)
      |=> reg_rd_data == {4'h0, $past(flag_r[`CEI_EV_C0_CAL]), 2'h0,
                          $past(flag_r[`CEI_EV_C0_AMP])})
      else $error("Converter 0 status read does not match event flags");

   a_status_conv1: assert property (reg_rd_en && (reg_addr == `CEI_ADDR_ST_CONV1)
      |=> reg_rd_data == {4'h0, $past(flag_r[`CEI_EV_C1_CAL]), 2'h0,
                          $past(flag_r[`CEI_EV_C1_AMP])})
      else $error("Converter 1 status read does not match event flags");

   a_status_clock: assert property (reg_rd_en && (reg_addr == `CEI_ADDR_ST_CLOCKING)
      |=> reg_rd_data == {2'h0, $past(flag_r[`CEI_EV_DLL_LOST:`CEI_EV_DLL_LOCK]), 2'h0,
                          $past(flag_r[`CEI_EV_PLL_LOST:`CEI_EV_PLL_LOCK])})
      else $error("Clocking status read does not match event flags");

   a_rd_unmapped: assert property (reg_rd_en
      && ((reg_addr < `CEI_ADDR_EN_MAIN) || (reg_addr > `CEI_ADDR_ST_CLOCKING))
      |=> reg_rd_valid && (reg_rd_data == `CEI_RESET_BYTE))
      else $error("Unmapped offset read returned nonzero data");

   // Pins: quiet with nothing enabled, low on a latch, released on a clear
   a_idle_pins: assert property ((en_vec == `CEI_RESET_EVT)
      |=> interrupt_out_first_n && interrupt_out_second_n)
      else $error("Interrupt pin driven with every event disabled");

   sequence s_fifo_latch_first;
      en_vec[`CEI_EV_LANE_FIFO] && lane_fifo_fault && !event_pin_select[`CEI_EV_LANE_FIFO];
   endsequence

   a_latch_pin: assert property (s_fifo_latch_first |=> !interrupt_out_first_n)
      else $error("Latched lane FIFO event did not pull the first pin low");

   a_clear_release: assert property (s_clear_req
      ##0 ((en_vec & ~(13'h0001 << `CEI_EV_LANE_FIFO)) == `CEI_RESET_EVT)
      |=> interrupt_out_first_n && interrupt_out_second_n)
      else $error("Write-one clear did not release the interrupt pins");

endmodule : cei_event_bank
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the converter event bank
`timescale 1ns/1ps
`default_nettype none
`include "cei_consts.svh"
module tb;
   import cei_pkg::*;
   logic         clk_sys      = 1'b0;
   logic         nrst         = 1'b0;
   logic         reg_wr_en    = 1'b0;
   logic         reg_rd_en    = 1'b0;
   cei_addr_type reg_addr     = 12'h000;
   cei_byte_type reg_wr_data  = 8'h00;
   cei_byte_type reg_rd_data;
   logic         reg_rd_valid;
   cei_evt_type  cond         = 13'h0000;
   cei_evt_type  sel          = 13'h0aaa;
   logic         irq_first_n;
   logic         irq_second_n;
   int           miscompares  = 0;
   int           checks_done  = 0;
   int           cycles       = 0;
   // Register group (0 main, 1 conv0, 2 conv1, 3 clocking) and bit of each event
   int           ev_reg [13]  = '{0, 0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 3, 3};
   int           ev_bit [13]  = '{0, 1, 2, 3, 4, 0, 3, 0, 3, 0, 1, 4, 5};
   cei_byte_type en_mask [4]  = '{`CEI_MASK_MAIN, `CEI_MASK_CONV, `CEI_MASK_CONV,
                                  `CEI_MASK_CLOCKING};

   // 25 MHz system clock
   always #20 clk_sys = ~clk_sys;

   cei_event_bank dut (
      .clk_sys                (clk_sys),
      .nrst                   (nrst),
      .reg_wr_en              (reg_wr_en),
      .reg_rd_en              (reg_rd_en),
      .reg_addr               (reg_addr),
      .reg_wr_data            (reg_wr_data),
      .reg_rd_data            (reg_rd_data),
      .reg_rd_valid           (reg_rd_valid),
      .ref_jitter_cond        (cond[4]),
      .link_receiver_ready    (~cond[3]),
      .lane_fifo_fault        (cond[2]),
      .pattern_err_imag       (cond[1]),
      .pattern_err_real       (cond[0]),
      .conv0_cal_complete     (cond[6]),
      .conv0_amp_protect      (cond[5]),
      .conv1_cal_complete     (cond[8]),
      .conv1_amp_protect      (cond[7]),
      .dll_locked             (cond[11]),
      .dll_lock_lost          (cond[12]),
      .pll_locked             (cond[9]),
      .pll_lock_lost          (cond[10]),
      .event_pin_select       (sel),
      .interrupt_out_first_n  (irq_first_n),
      .interrupt_out_second_n (irq_second_n)
   );

   // Verdict and end of run, reached from the main sequence or the timeout
   task automatic end_of_test();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input cei_byte_type exp, input cei_byte_type got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bus tasks enter and leave on a falling edge; one idle cycle follows
   // each transfer so a strobe is never dropped and raised in one step
   task automatic tick();
      @(negedge clk_sys);
   endtask

   task automatic wr(input cei_addr_type a, input cei_byte_type d);
      reg_wr_en   = 1'b1;
      reg_addr    = a;
      reg_wr_data = d;
      tick();
      reg_wr_en   = 1'b0;
      tick();
   endtask

   // Read data and valid are registered, so both stand at the next falling edge
   task automatic rd(input cei_addr_type a, input cei_byte_type exp);
      reg_rd_en = 1'b1;
      reg_addr  = a;
      tick();
      reg_rd_en = 1'b0;
      chk("rd_valid", 8'h01, {7'h00, reg_rd_valid});
      chk($sformatf("reg %h", a), exp, reg_rd_data);
      tick();
   endtask

   task automatic pins(input logic f, input logic s);
      chk("first_n", {7'h00, f}, {7'h00, irq_first_n});
      chk("second_n", {7'h00, s}, {7'h00, irq_second_n});
   endtask

   // Hang guard: the whole sequence needs well under 2000 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         $display("[ERR] run length expected below 2000 seen 2000");
         end_of_test();
      end
   end

   initial begin
      cei_addr_type ea;
      cei_addr_type sa;
      cei_byte_type b;
      repeat (12) tick();
      nrst = 1'b1;
      // Everything comes out of reset cleared with both pins released
      for (int r = 0; r < 8; r++) begin
         rd(`CEI_ADDR_EN_MAIN + 12'(r), `CEI_RESET_BYTE);
      end
      pins(1'b1, 1'b1);
      $display("test reset_values done");
      // Only documented enable bits stick; the unmapped offset reads zero
      for (int r = 0; r < 4; r++) begin
         wr(`CEI_ADDR_EN_MAIN + 12'(r), 8'hff);
         rd(`CEI_ADDR_EN_MAIN + 12'(r), en_mask[r]);
         wr(`CEI_ADDR_EN_MAIN + 12'(r), 8'h00);
      end
      wr(12'h030, 8'hff);
      rd(12'h030, 8'h00);
      $display("test enable_masks done");
      // Each event in turn: live follow, latch, routing, refused and real clear
      for (int i = 0; i < `CEI_NUM_EVENTS; i++) begin
         ea = `CEI_ADDR_EN_MAIN + 12'(ev_reg[i]);
         sa = `CEI_ADDR_ST_MAIN + 12'(ev_reg[i]);
         b  = 8'h01 << ev_bit[i];
         cond[i] = 1'b1;
         tick();
         rd(sa, b);
         pins(1'b1, 1'b1);
         cond[i] = 1'b0;
         tick();
         rd(sa, 8'h00);
         wr(ea, b);
         cond[i] = 1'b1;
         tick();
         cond[i] = 1'b0;
         tick();
         tick();
         pins(sel[i], ~sel[i]);
         rd(sa, b);
         // Clearing while the condition is still present must not take
         cond[i] = 1'b1;
         wr(sa, b);
         cond[i] = 1'b0;
         rd(sa, b);
         wr(sa, b);
         rd(sa, 8'h00);
         pins(1'b1, 1'b1);
         wr(ea, 8'h00);
      end
      $display("test per_event done");
      // Two latched events on the first pin: it stays low until both are cleared
      wr(`CEI_ADDR_EN_MAIN, 8'h05);
      cond[0] = 1'b1;
      cond[2] = 1'b1;
      tick();
      cond[0] = 1'b0;
      cond[2] = 1'b0;
      wr(`CEI_ADDR_ST_MAIN, 8'h01);
      pins(1'b0, 1'b1);
      rd(`CEI_ADDR_ST_MAIN, 8'h04);
      wr(`CEI_ADDR_ST_MAIN, 8'h04);
      pins(1'b1, 1'b1);
      $display("test shared_pin done");
      end_of_test();
   end
endmodule // tb
`default_nettype wire
